//--- design/irq_pend_prio_pkg.sv
// Operation
// - Set-pending write ones mark interrupts pending.
// - Set-pending read returns current pending vector.
// - Clear-pending write ones make interrupts not pending; here only while the line is low.
// - Clear-pending read returns same pending vector.
// - Eight priority registers cover 32 interrupts.
// - Register n lanes hold interrupts 4n..4n+3.
// - Two-bit field in lane top; rest RAZ/WI.
// - Implemented priorities write and read back.
// - Unimplemented interrupt priority reads zero, ignores writes.
// - Line edge or software sets; entry/deassertion clears.
// - Simultaneous set and clear: set wins here.
package irq_pend_prio_pkg;

  localparam int IRQ_MAX = 32;
  localparam logic [31:0] ADDR_PEND_SET = 32'he000e200;
  localparam logic [31:0] ADDR_PEND_CLR = 32'he000e280;
  localparam logic [31:0] ADDR_PRIO_BASE = 32'he000e400;
  localparam int PRIO_REG_COUNT = 8;
  localparam int PRIO_IDX_W = 3;
  localparam int LANES_PER_REG = 4;
  localparam int LANE_WIDTH = 8;
  localparam int PRIO_WIDTH = 2;
  localparam int PRIO_FIELD_LSB = 6;
  localparam int PRIO_WORD_W = LANES_PER_REG * PRIO_WIDTH;
  localparam logic [31:0] PEND_RESET = 32'h0000_0000;
  localparam logic [PRIO_WORD_W-1:0] PRIO_RESET = 8'h00;

endpackage

//--- design/prio_store.sv
`timescale 1ns/1ps
// Small storage for the packed priority fields, one word per priority register.
module prio_store
  import irq_pend_prio_pkg::*;
#(
  parameter int DEPTH = PRIO_REG_COUNT,
  parameter int AW = PRIO_IDX_W,
  parameter int DW = PRIO_WORD_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // Read port, data registered
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= PRIO_RESET;
      end
    end else if (wrEn) begin
      mem_r[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData <= PRIO_RESET;
    end else begin
      rdData <= mem_r[rdAddr];
    end
  end

endmodule

//--- design/irq_pend_prio.sv
`timescale 1ns/1ps
// Pending-state and priority registers of the vectored interrupt controller.
// Reads complete two cycles after the request; writes take effect at the next edge.
module irq_pend_prio
  import irq_pend_prio_pkg::*;
#(
  parameter int NUM_IRQ = IRQ_MAX
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Private peripheral bus register port, word accesses
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [31:0] busWdata,
  output logic [31:0] busRdata,
  output logic busRvalid,
  // Interrupt inputs
  input wire logic [IRQ_MAX-1:0] irqLine,
  // Exception entry from the core
  input wire logic excEntry,
  input wire logic [4:0] excEntryNum,
  // Pending vector to the prioritisation logic
  output logic [IRQ_MAX-1:0] pendingOut
);

  // Interrupts beyond NUM_IRQ are not provided and hold no state.
  localparam logic [IRQ_MAX-1:0] IMPL_MASK = (NUM_IRQ >= IRQ_MAX) ? '1 :
    IRQ_MAX'((64'h1 << NUM_IRQ) - 64'h1);

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_PEND,
    SRC_PRIO
  } rd_src_t;

  function automatic logic isPrioAddr(input logic [31:0] a);
    logic [31:0] off;
    off = a - ADDR_PRIO_BASE;
    isPrioAddr = (a >= ADDR_PRIO_BASE) && (off[1:0] == 2'b00) &&
      (off[31:2] < 30'(PRIO_REG_COUNT));
  endfunction

  function automatic logic [PRIO_IDX_W-1:0] prioIdx(input logic [31:0] a);
    logic [31:0] off;
    off = a - ADDR_PRIO_BASE;
    prioIdx = off[PRIO_IDX_W+1:2];
  endfunction

  function automatic logic isPendAddr(input logic [31:0] a);
    isPendAddr = (a == ADDR_PEND_SET) || (a == ADDR_PEND_CLR);
  endfunction

  // Mask of priority fields in register idx that belong to implemented interrupts.
  function automatic logic [PRIO_WORD_W-1:0] laneMask(input logic [PRIO_IDX_W-1:0] idx);
    logic [PRIO_WORD_W-1:0] m;
    m = '0;
    for (int l = 0; l < LANES_PER_REG; l++) begin
      if (int'(idx) * LANES_PER_REG + l < NUM_IRQ) begin
        m[l*PRIO_WIDTH +: PRIO_WIDTH] = '1;
      end
    end
    laneMask = m;
  endfunction

  logic [IRQ_MAX-1:0] pend_r;
  logic [IRQ_MAX-1:0] pend_nxt;
  logic [IRQ_MAX-1:0] lineDly_r;
  logic [IRQ_MAX-1:0] setVec;
  logic [IRQ_MAX-1:0] clrVec;
  logic [IRQ_MAX-1:0] entryVec;
  logic wrSet;
  logic wrClr;
  logic wrPrio;
  logic [PRIO_WORD_W-1:0] prioWrPacked;
  logic [PRIO_WORD_W-1:0] prioRdPacked;
  rd_src_t rdSrc_r;
  logic rdPend1_r;
  logic [IRQ_MAX-1:0] rdPendVal_r;
  logic [PRIO_IDX_W-1:0] rdIdx_r;
  logic [31:0] prioRdWord;
  logic [PRIO_IDX_W-1:0] busIdx;
  logic [PRIO_WORD_W-1:0] rdLaneMask;

  assign wrSet = busWrite && (busAddr == ADDR_PEND_SET);
  assign wrClr = busWrite && (busAddr == ADDR_PEND_CLR);
  assign wrPrio = busWrite && isPrioAddr(busAddr);
  assign busIdx = prioIdx(busAddr);
  assign rdLaneMask = laneMask(rdIdx_r);

  always_comb begin
    entryVec = '0;
    if (excEntry) begin
      entryVec[excEntryNum] = 1'b1;
    end
  end

  // A clear-pending write only counts as deassertion while the line is low, so a
  // still-high line keeps its interrupt pending.
  always_comb begin
    setVec = (irqLine & ~lineDly_r) | (wrSet ? busWdata : '0);
    clrVec = entryVec | ((wrClr ? busWdata : '0) & ~irqLine);
    pend_nxt = (setVec | (pend_r & ~clrVec)) & IMPL_MASK;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_r <= PEND_RESET;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lineDly_r <= '0;
    end else begin
      lineDly_r <= irqLine;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pendingOut <= PEND_RESET;
    end else begin
      pendingOut <= pend_nxt;
    end
  end

  // Only the top two bits of each byte lane are kept; the rest are discarded.
  always_comb begin
    prioWrPacked = '0;
    for (int l = 0; l < LANES_PER_REG; l++) begin
      prioWrPacked[l*PRIO_WIDTH +: PRIO_WIDTH] =
        busWdata[l*LANE_WIDTH + PRIO_FIELD_LSB +: PRIO_WIDTH];
    end
    prioWrPacked = prioWrPacked & laneMask(busIdx);
  end

  prio_store #(
    .DEPTH(PRIO_REG_COUNT),
    .AW(PRIO_IDX_W),
    .DW(PRIO_WORD_W)
  ) u_prio_store (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wrPrio),
    .wrAddr(busIdx),
    .wrData(prioWrPacked),
    .rdAddr(busIdx),
    .rdData(prioRdPacked)
  );

  // First read stage: remember the request, its target and the register index.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdPend1_r <= 1'b0;
    end else begin
      rdPend1_r <= busRead;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdIdx_r <= '0;
    end else begin
      rdIdx_r <= busIdx;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdSrc_r <= SRC_NONE;
    end else if (isPendAddr(busAddr)) begin
      rdSrc_r <= SRC_PEND;
    end else if (isPrioAddr(busAddr)) begin
      rdSrc_r <= SRC_PRIO;
    end else begin
      rdSrc_r <= SRC_NONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdPendVal_r <= PEND_RESET;
    end else begin
      rdPendVal_r <= pend_r;
    end
  end

  always_comb begin
    prioRdWord = '0;
    for (int l = 0; l < LANES_PER_REG; l++) begin
      prioRdWord[l*LANE_WIDTH + PRIO_FIELD_LSB +: PRIO_WIDTH] =
        prioRdPacked[l*PRIO_WIDTH +: PRIO_WIDTH] &
        rdLaneMask[l*PRIO_WIDTH +: PRIO_WIDTH];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busRvalid <= 1'b0;
    end else begin
      busRvalid <= rdPend1_r;
    end
  end

  // Second read stage: return the word; unmapped addresses read as zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busRdata <= '0;
    end else begin
      if (rdPend1_r) begin
        unique case (rdSrc_r)
          SRC_PEND: busRdata <= rdPendVal_r;
          SRC_PRIO: busRdata <= prioRdWord;
          SRC_NONE: busRdata <= '0;
          default: busRdata <= '0;
        endcase
      end
    end
  end

endmodule

//--- bench/irq_pend_prio_props.sv
`timescale 1ns/1ps
module irq_pend_prio_props
  import irq_pend_prio_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [31:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic [31:0] busWdata,
  input wire logic [31:0] busRdata,
  input wire logic busRvalid,
  // Interrupt side
  input wire logic [31:0] irqLine,
  input wire logic excEntry,
  input wire logic [4:0] excEntryNum,
  input wire logic [31:0] pendingOut
);
  logic [31:0] prevIrq_r;
  logic [31:0] rise;

  always_ff @(posedge mclk) begin
    prevIrq_r <= sys_rst ? 32'h0 : irqLine;
  end

  assign rise = irqLine & ~prevIrq_r;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  property p_rd;
    busRead |-> ##2 busRvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_pend;
    busRead && busAddr == ADDR_PEND_CLR |-> ##2 busRdata == $past(pendingOut, 2);
  endproperty
  a_pend: assert property (p_pend) else $error("clear-pending read data wrong");
  property p_pset;
    busRead && busAddr == ADDR_PEND_SET |-> ##2 busRdata == $past(pendingOut, 2);
  endproperty
  a_pset: assert property (p_pset) else $error("set-pending read data wrong");
  property p_set;
    busWrite && busAddr == ADDR_PEND_SET
      |=> (pendingOut & $past(busWdata)) == $past(busWdata);
  endproperty
  a_set: assert property (p_set) else $error("set-pending write lost");
  property p_clr;
    busWrite && busAddr == ADDR_PEND_CLR
      |=> (pendingOut & $past(busWdata) & ~$past(irqLine)) == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear-pending write lost");
  property p_edge;
    rise != 32'h0 |=> (pendingOut & $past(rise)) == $past(rise);
  endproperty
  a_edge: assert property (p_edge) else $error("line edge not pending");
  property p_entry;
    excEntry && !busWrite && !rise[excEntryNum] |=> !pendingOut[$past(excEntryNum)];
  endproperty
  a_entry: assert property (p_entry) else $error("entry did not clear pending");
  property p_rst;
    disable iff (1'h0) sys_rst |=> pendingOut == 32'h0 && !busRvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_raz;
    busRvalid && ($past(busAddr, 2) & 32'hffff_ffe0) == ADDR_PRIO_BASE
      |-> (busRdata & 32'h3f3f_3f3f) == 32'h0;
  endproperty
  a_raz: assert property (p_raz) else $error("reserved priority bits not zero");
endmodule

bind irq_pend_prio irq_pend_prio_props u_props (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .busAddr(busAddr),
  .busWrite(busWrite),
  .busRead(busRead),
  .busWdata(busWdata),
  .busRdata(busRdata),
  .busRvalid(busRvalid),
  .irqLine(irqLine),
  .excEntry(excEntry),
  .excEntryNum(excEntryNum),
  .pendingOut(pendingOut)
);

//--- bench/ppb_master.sv
`timescale 1ns/1ps
module ppb_master (
  // Register port
  input wire logic mclk,
  output logic [31:0] busAddr = 32'h0,
  output logic [31:0] busWdata = 32'h0,
  output logic busWrite = 1'h0,
  output logic busRead = 1'h0,
  input wire logic [31:0] busRdata,
  input wire logic busRvalid
);
  // Word access; idle address and data show the inverse of the last value.
  task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q);
    q = 32'hx;
    @(posedge mclk);
    #1;
    {busWrite, busRead, busAddr, busWdata} = {wr, ~wr, a, d};
    @(posedge mclk);
    #1;
    {busWrite, busRead, busAddr, busWdata} = {2'h0, ~a, ~d};
    // Read data are taken just after the edge that raised busRvalid, while they stand.
    repeat (3) begin
      @(posedge mclk);
      #1;
      if (busRvalid === 1'b1) begin
        q = busRdata;
      end
    end
  endtask
endmodule

//--- bench/irq_pend_prio_tb.sv
`timescale 1ns/1ps
module irq_pend_prio_tb;
  import irq_pend_prio_pkg::*;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic excEntry = 1'h0;
  logic [4:0] excEntryNum = 5'h0;
  logic [31:0] irqLine = 32'h0;
  logic [31:0] busAddr, busWdata, busRdata, pendingOut, rv, w;
  logic busWrite, busRead, busRvalid;
  int fail_count = 0, checked = 0;
  always #12.5 mclk = ~mclk;
  irq_pend_prio uut (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .busAddr(busAddr),
    .busWrite(busWrite),
    .busRead(busRead),
    .busWdata(busWdata),
    .busRdata(busRdata),
    .busRvalid(busRvalid),
    .irqLine(irqLine),
    .excEntry(excEntry),
    .excEntryNum(excEntryNum),
    .pendingOut(pendingOut)
  );
  ppb_master m (
    .mclk(mclk),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busWrite(busWrite),
    .busRead(busRead),
    .busRdata(busRdata),
    .busRvalid(busRvalid)
  );
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdChk(input string nm, input logic [31:0] a, exp);
    m.xfer(1'h0, a, 32'h0, rv);
    chk(nm, rv, exp);
  endtask
  task automatic test_done;
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'h0;
    rdChk("pend", ADDR_PEND_SET, 32'h0);
    rdChk("prio", ADDR_PRIO_BASE, 32'h0);
    m.xfer(1'h1, ADDR_PEND_SET, 32'ha5a5_0f0f, rv);
    rdChk("set", ADDR_PEND_CLR, 32'ha5a5_0f0f);
    m.xfer(1'h1, ADDR_PEND_CLR, 32'hf0f, rv);
    rdChk("clr", ADDR_PEND_SET, 32'ha5a5_0000);
    irqLine = 32'h4000_0000;
    m.xfer(1'h1, ADDR_PEND_CLR, irqLine, rv);
    rdChk("line", ADDR_PEND_SET, 32'he5a5_0000);
    irqLine = 32'h0;
    m.xfer(1'h1, ADDR_PEND_CLR, 32'h4000_0000, rv);
    excEntryNum = 5'h10;
    excEntry = 1'h1;
    @(posedge mclk);
    #1;
    excEntry = 1'h0;
    chk("entry", pendingOut, 32'ha5a4_0000);
    @(posedge mclk);
    #1;
    irqLine = 32'h0001_0000;
    excEntry = 1'h1;
    @(posedge mclk);
    #1;
    irqLine = 32'h0;
    excEntry = 1'h0;
    chk("setWins", pendingOut, 32'ha5a5_0000);
    for (int n = 0; n < 8; n++) begin
      w = {n[1:0], 6'h3f, ~n[1:0], 6'h15, n[2:1], 6'h2a, 8'hff};
      m.xfer(1'h1, ADDR_PRIO_BASE + 32'(4 * n), w, rv);
      rdChk("prio", ADDR_PRIO_BASE + 32'(4 * n), w & 32'hc0c0_c0c0);
    end
    m.xfer(1'h1, ADDR_PRIO_BASE + 32'h20, 32'hffff_ffff, rv);
    rdChk("beyond", ADDR_PRIO_BASE + 32'h20, 32'h0);
    for (int n = 0; n < 8; n++) begin
      w = {n[1:0], 6'h3f, ~n[1:0], 6'h15, n[2:1], 6'h2a, 8'hff};
      rdChk("bank", ADDR_PRIO_BASE + 32'(4 * n), w & 32'hc0c0_c0c0);
    end
    sys_rst = 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    sys_rst = 1'h0;
    chk("rstOut", pendingOut, 32'h0);
    rdChk("rstPend", ADDR_PEND_CLR, 32'h0);
    rdChk("rstPrio", ADDR_PRIO_BASE + 32'h1c, 32'h0);
    test_done();
  end
endmodule
